// ---- dv/odac_assertions.sv ----
`timescale 1ns/1ps
module odac_assertions
  import odac_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic accumulator_clear_pulse,
  input wire logic accumulator_clear_slave,
  input wire logic roundoff_gate,
  input wire logic step_one_req,
  input wire logic step_zero_req,
  input wire logic shift_right,
  input wire logic shift_left,
  input wire logic complement_subtract,
  input wire logic adder_carry_in,
  input wire logic op_go,
  input wire logic op_done
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_clear; accumulator_clear_pulse; endsequence
  sequence s_proceed; roundoff_gate || op_go; endsequence
  property p_after_clear; s_clear |-> ##[1:20] s_proceed; endproperty
  property p_go_done; op_go |-> ##[1:300] op_done; endproperty
  property p_one_pulse; s_clear |=> !accumulator_clear_pulse; endproperty
  property p_no_slave; !accumulator_clear_slave; endproperty
  property p_block; roundoff_gate |-> !(step_one_req || step_zero_req);
  endproperty
  property p_carry; adder_carry_in == complement_subtract; endproperty
  property p_dir; shift_right != shift_left; endproperty
  property p_go_clean; op_go |-> !roundoff_gate && !accumulator_clear_pulse;
  endproperty
  property p_excl; !(step_one_req && step_zero_req); endproperty
  a_after_clear: assert property (p_after_clear)
    else $error("no progress after clear");
  a_go_done: assert property (p_go_done)
    else $error("operation never ended");
  a_one_pulse: assert property (p_one_pulse)
    else $error("clear pulse too long");
  a_no_slave: assert property (p_no_slave)
    else $error("slave clear issued");
  a_block: assert property (p_block)
    else $error("step request during roundoff");
  a_carry: assert property (p_carry)
    else $error("carry in differs from complement");
  a_dir: assert property (p_dir)
    else $error("shift direction outputs disagree");
  a_go_clean: assert property (p_go_clean)
    else $error("proceeded with clear or roundoff pending");
  a_excl: assert property (p_excl)
    else $error("both step requests high");
endmodule : odac_assertions
bind odac_top odac_assertions i_chk (.hclk, .hresetn,
  .accumulator_clear_pulse, .accumulator_clear_slave, .roundoff_gate,
  .step_one_req, .step_zero_req, .shift_right, .shift_left,
  .complement_subtract, .adder_carry_in, .op_go, .op_done);

// ---- dv/odac_far_model.sv ----
`timescale 1ns/1ps
module odac_far_model (
  input  wire logic hclk,
  input  wire logic slow,
  input  wire logic step_one_req,
  input  wire logic step_zero_req,
  input  wire logic roundoff_gate,
  input  wire logic accumulator_clear_pulse,
  input  wire logic complement_subtract,
  output logic      step_done,
  output logic      acc_frac1_one,
  output logic      acc_lsb,
  output logic      comp_gate_echo
);
  logic [3:0] wait_cnt = 4'h0;
  initial begin
    step_done = 1'b0;
    acc_frac1_one = 1'b0;
    acc_lsb = 1'b0;
  end
  // Gate driver echoes its input, so a good check always matches
  assign comp_gate_echo = complement_subtract;
  always @(posedge hclk) begin
    acc_lsb <= ~acc_lsb;
    if (accumulator_clear_pulse)
      acc_frac1_one <= 1'b0;
    else if (roundoff_gate)
      acc_frac1_one <= 1'b1;
    if (!(step_one_req || step_zero_req)) begin
      step_done <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (!step_done) begin
      if (wait_cnt >= (slow ? 4'h5 : 4'h0))
        step_done <= 1'b1;
      else
        wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule : odac_far_model

// ---- dv/tb_order_decode_arith_control.sv ----
`timescale 1ns/1ps
`include "odac_defines.svh"
module tb_order_decode_arith_control;
  import odac_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, addend_sign = 0;
  logic slow = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, acc_frac1_one, acc_lsb, step_done, comp_gate_echo;
  logic accumulator_clear_pulse, accumulator_clear_slave, roundoff_gate;
  logic step_one_req, step_zero_req, shift_right, shift_left, op_go;
  logic complement_subtract, adder_carry_in, op_done, reg2_frac1_load;
  logic reg2_frac1_data, reg2_select, add_class, mul_div_class, comp_seen;
  logic multiply_pos, extract_pos;
  logic [1:0] matrix_code;
  odac_mem_type mem_action;
  int n_mismatch = 0, compares = 0, n_go = 0, n_clr = 0, n_load = 0;
  int n_done = 0, n_gate = 0, n_req = 0, g, c, l, r0;
  // Rows: clear, subtract, absval, addend sign, expected complement
  localparam logic [4:0] ROWS [8] = '{5'h02, 5'h19, 5'h07, 5'h14,
                                      5'h0d, 5'h1e, 5'h12, 5'h0b};
  always #20 hclk = ~hclk;
  always @(posedge hclk) begin
    n_go += int'(op_go);
    n_clr += int'(accumulator_clear_pulse);
    n_load += int'(reg2_frac1_load);
    n_done += int'(op_done);
    n_gate += int'(roundoff_gate);
    n_req += int'(step_one_req || step_zero_req);
    if (op_go) comp_seen = complement_subtract;
  end
  odac_top i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .addend_sign,
    .acc_frac1_one, .acc_lsb, .step_done, .comp_gate_echo,
    .accumulator_clear_pulse, .accumulator_clear_slave, .roundoff_gate,
    .step_one_req, .step_zero_req, .shift_right, .shift_left,
    .complement_subtract, .adder_carry_in, .op_go, .op_done,
    .reg2_frac1_load, .reg2_frac1_data, .mem_action, .reg2_select,
    .add_class, .mul_div_class, .multiply_pos, .extract_pos, .matrix_code);
  odac_far_model i_far (.hclk, .slow, .step_one_req, .step_zero_req,
    .roundoff_gate, .accumulator_clear_pulse, .complement_subtract,
    .step_done, .acc_frac1_one, .acc_lsb, .comp_gate_echo);
  task automatic conclude;
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic rdy;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (k >= 50) begin
      n_mismatch++;
      conclude();
    end
  endtask : rdy
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    rdy();
    q = hrdata;
  endtask : bus
  task automatic wait_done;
    int was, k;
    was = n_done;
    k = 0;
    while (n_done == was && k < 600) begin
      @(posedge hclk);
      k++;
    end
    if (k >= 600) begin
      n_mismatch++;
      conclude();
    end
  endtask : wait_done
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk(shift_left, 1);
    chk(hresp, 0);
    bus(0, `ODAC_ORDER_OFS, 0);
    chk(q, `ODAC_ORDER_RST);
    bus(0, 8'h40, 0);
    chk(q, 0);
    for (int i = 0; i < 8; i++) begin
      addend_sign <= ROWS[i][1];
      slow <= i[0];
      bus(1, `ODAC_ORDER_OFS, {23'h3, i[1:0], i[2], ROWS[i][4],
                               ROWS[i][2], ROWS[i][3], 1'b0});
      c = n_clr;
      l = n_load;
      bus(1, `ODAC_CTRL_OFS, 1);
      wait_done();
      chk(comp_seen, ROWS[i][0]);
      chk(n_clr - c, ROWS[i][4]);
      chk(n_load - l, 4);
      chk(mem_action, {i[0], i[1]});
      chk(add_class, 1);
      chk(reg2_select, i[2]);
      chk(matrix_code, {ROWS[i][3], ROWS[i][2]});
      bus(1, `ODAC_CTRL_OFS, 0);
    end
    // Multiply with clear and roundoff
    c = n_clr;
    g = n_gate;
    bus(1, `ODAC_ORDER_OFS, 32'h009);
    // Decodes are looked at once the written order has settled
    repeat (5) @(posedge hclk);
    chk(multiply_pos, 1);
    chk(mul_div_class, 1);
    chk(extract_pos, 0);
    chk(n_clr, c);
    bus(1, `ODAC_CTRL_OFS, 1);
    wait_done();
    chk(n_clr - c, 1);
    chk(n_gate > g, 1);
    bus(1, `ODAC_CTRL_OFS, 0);
    // Roundoff without clear never proceeds
    g = n_go;
    r0 = n_req;
    bus(1, `ODAC_ORDER_OFS, 32'h181);
    bus(1, `ODAC_CTRL_OFS, 1);
    repeat (100) @(posedge hclk);
    chk(n_go - g, 0);
    chk(n_req - r0, 0);
    bus(1, `ODAC_ORDER_OFS, 0);
    bus(0, `ODAC_ORDER_OFS, 0);
    chk(q, 32'h181);
    bus(1, `ODAC_CTRL_OFS, 0);
    // Extract-class decode, then a reset while the order is still pending
    bus(1, `ODAC_ORDER_OFS, 32'h114);
    @(posedge hclk);
    chk(extract_pos, 1);
    chk(reg2_select, 0);
    chk(matrix_code, 2'b01);
    chk(shift_left, 0);
    chk(shift_right, 1);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk(shift_left, 1);
    chk(extract_pos, 0);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(0, `ODAC_ORDER_OFS, 0);
    chk(q, `ODAC_ORDER_RST);
    conclude();
  end
endmodule : tb_order_decode_arith_control

// ---- hw/odac_top.sv ----
// The implementer's own choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
// Functional notes
// - Roundoff flag orders a one at accumulator first fraction; needs clear too.
// - Add/sub, absval and addend sign set complement; add/sub and absval also feed decode matrix.
// - Clear-hold one clears accumulator; flag returns to zero before proceeding.
// - Second-register select sensed on all orders but multiply/extract class.
// - Two memory flags decode read, write, order counter or shift counter.
// - Add/multiply flag separates addition class from multiply and divide.
// - Shift-direction flag supplies left or right signal to shift sequencer.
// - Multiply and extract decode outputs are active-positive.
// - Multiplication roundoff clears accumulator then sets first fraction bit.
// - No arithmetic proceeds until clear-hold and roundoff are both zero.
// - Roundoff without clear never resets roundoff; block stalls.
// - Operate with clear gives master clear pulse only, no slave clear.
// - After clear pulse clear-hold resets; without roundoff operation proceeds.
// - With roundoff, gate one in, wait until set, then reset roundoff.
// - While roundoff set, zero and one step requests are blocked.
// - Eight addition orders from clear, add/subtract and absval choices.
// - Addition sets complement, then four right steps and four left steps.
// - Subtract for subtract, add absval of negative, sub absval of positive.
// - Subtract setting injects carry into first adder stage.
// - Complement latched in check flag, compared with driver; proceed on match.
// - Addition sets shift direction right, sending the one step request.
// - Each right shift moves accumulator lsb into second register fraction.
// - Orders load only in control sequence; execution waits for operate.
`include "odac_defines.svh"

module odac_top
  import odac_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        addend_sign,
  input  wire logic        acc_frac1_one,
  input  wire logic        acc_lsb,
  input  wire logic        step_done,
  input  wire logic        comp_gate_echo,
  output logic             accumulator_clear_pulse,
  output logic             accumulator_clear_slave,
  output logic             roundoff_gate,
  output logic             step_one_req,
  output logic             step_zero_req,
  output logic             shift_right,
  output logic             shift_left,
  output logic             complement_subtract,
  output logic             adder_carry_in,
  output logic             op_go,
  output logic             op_done,
  output logic             reg2_frac1_load,
  output logic             reg2_frac1_data,
  output odac_mem_type     mem_action,
  output logic             reg2_select,
  output logic             add_class,
  output logic             mul_div_class,
  output logic             multiply_pos,
  output logic             extract_pos,
  output logic [1:0]       matrix_code
);

  // Pin index in the synchroniser
  localparam int unsigned P_SIGN = 0;
  localparam int unsigned P_FRAC = 1;
  localparam int unsigned P_LSB  = 2;
  localparam int unsigned P_STEP = 3;
  localparam int unsigned P_ECHO = 4;

  odac_regs_type r_ff;
  odac_regs_type nxt_r;

  // Subtract decision from the flags and addend sign
  function automatic logic comp_select(input odac_order_type o,
                                       input logic sign_neg);
    comp_select = o.number_absval_flag ? (o.add_sub_flag ^ sign_neg)
                                       : o.add_sub_flag;
  endfunction : comp_select

  function automatic logic [31:0] read_mux(input odac_regs_type s,
                                           input logic [7:0] a);
    read_mux = 32'h0000_0000;
    case (a)
      `ODAC_ORDER_OFS:  read_mux = {23'h000000, s.ord};
      `ODAC_CTRL_OFS:   read_mux = {31'h00000000, s.operate};
      `ODAC_STATUS_OFS: read_mux = {20'h00000, s.step_cnt,
                                    1'b0, s.st, s.comp_sub,
                                    s.complement_check_flag,
                                    s.pending, s.ord.shift_direction_flag};
      `ODAC_PINS_OFS:   read_mux = {27'h0000000, s.sy.s2};
      default:          read_mux = 32'h0000_0000;
    endcase
  endfunction : read_mux

  logic step_edge;
  logic comp_now;
  logic is_add;
  logic rd_take;

  always_comb begin
    nxt_r     = r_ff;
    is_add    = r_ff.ord.add_vs_multiply_flag;
    comp_now  = comp_select(r_ff.ord, r_ff.sy.s2[P_SIGN]);
    step_edge = r_ff.sy.s2[P_STEP] & ~r_ff.step_seen;
    rd_take   = hsel & hready & htrans[1] & ~hwrite;

    nxt_r.sy.s1     = {comp_gate_echo, step_done, acc_lsb,
                       acc_frac1_one, addend_sign};
    nxt_r.sy.s2     = r_ff.sy.s1;
    nxt_r.step_seen = r_ff.sy.s2[P_STEP];
    nxt_r.clr_pulse = 1'b0;
    nxt_r.go        = 1'b0;
    nxt_r.fin       = 1'b0;
    nxt_r.r2_load   = 1'b0;

    // Bus address phase; zero wait, read data captured for the data phase
    nxt_r.ap_sel  = hsel & hready & htrans[1];
    nxt_r.ap_wr   = hwrite;
    nxt_r.ap_addr = haddr[7:0];
    if (rd_take) begin
      nxt_r.rdata = read_mux(r_ff, haddr[7:0]);
    end

    // Bus data phase writes
    if (r_ff.ap_sel && r_ff.ap_wr) begin
      case (r_ff.ap_addr)
        `ODAC_ORDER_OFS: begin
          // Orders load during the control sequence only
          if (!r_ff.operate && r_ff.st == ODAC_IDLE) begin
            nxt_r.ord     = odac_order_type'(hwdata[`ODAC_ORDER_W-1:0]);
            nxt_r.pending = 1'b1;
          end
        end
        `ODAC_CTRL_OFS: begin
          nxt_r.operate = hwdata[`ODAC_CTL_OPERATE];
        end
        default: begin
        end
      endcase
    end

    case (r_ff.st)
      ODAC_IDLE: begin
        // Execution waits for the operate sequence
        if (r_ff.pending && r_ff.operate) begin
          nxt_r.pending = 1'b0;
          if (r_ff.ord.clear_hold_flag) begin
            nxt_r.st        = ODAC_CLEAR;
            nxt_r.clr_pulse = 1'b1;
          end else if (r_ff.ord.roundoff_flag) begin
            // Nothing will ever reset roundoff here
            nxt_r.st = ODAC_STALL;
          end else if (is_add) begin
            nxt_r.st = ODAC_COMP;
          end else begin
            nxt_r.st = ODAC_DONE;
            nxt_r.go = 1'b1;
          end
        end
      end
      ODAC_CLEAR: begin
        // Clear pulse is high during this state and ends with it: drop clear-hold
        nxt_r.ord.clear_hold_flag = 1'b0;
        nxt_r.st                  = ODAC_CLRWAIT;
      end
      ODAC_CLRWAIT: begin
        if (r_ff.ord.roundoff_flag) begin
          nxt_r.st       = ODAC_ROUND;
          nxt_r.rnd_gate = 1'b1;
        end else if (is_add) begin
          nxt_r.st = ODAC_COMP;
        end else begin
          nxt_r.st = ODAC_DONE;
          nxt_r.go = 1'b1;
        end
      end
      ODAC_ROUND: begin
        // Wait for the bit to be fully one before releasing
        if (r_ff.sy.s2[P_FRAC]) begin
          nxt_r.rnd_gate          = 1'b0;
          nxt_r.ord.roundoff_flag = 1'b0;
          if (is_add) begin
            nxt_r.st = ODAC_COMP;
          end else begin
            nxt_r.st = ODAC_DONE;
            nxt_r.go = 1'b1;
          end
        end
      end
      ODAC_COMP: begin
        // Complement set and latched, then checked against driver echo
        nxt_r.comp_sub              = comp_now;
        nxt_r.complement_check_flag = comp_now;
        if (r_ff.comp_sub == comp_now &&
            r_ff.complement_check_flag == r_ff.sy.s2[P_ECHO]) begin
          nxt_r.st                       = ODAC_STEP;
          nxt_r.go                       = 1'b1;
          nxt_r.step_cnt                 = 4'h0;
          nxt_r.ord.shift_direction_flag = 1'b1;
        end
      end
      ODAC_STEP: begin
        if (step_edge) begin
          if (r_ff.ord.shift_direction_flag) begin
            nxt_r.r2_load = 1'b1;
            nxt_r.r2_data = r_ff.sy.s2[P_LSB];
          end
          nxt_r.step_cnt = r_ff.step_cnt + 4'h1;
          if (r_ff.step_cnt + 4'h1 == `ODAC_RIGHT_STEPS) begin
            nxt_r.ord.shift_direction_flag = 1'b0;
          end
          if (r_ff.step_cnt + 4'h1 == `ODAC_ADD_STEPS) begin
            nxt_r.st = ODAC_DONE;
          end
        end
      end
      ODAC_DONE: begin
        nxt_r.fin = 1'b1;
        nxt_r.st  = ODAC_IDLE;
      end
      ODAC_STALL: begin
        // Hang is left only by the sequencer leaving operate
        if (!r_ff.operate) begin
          nxt_r.st = ODAC_IDLE;
        end
      end
      default: begin
        nxt_r.st = ODAC_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_ff                       <= '0;
      r_ff.st                    <= ODAC_IDLE;
      r_ff.ord                   <= odac_order_type'(`ODAC_ORDER_RST);
      r_ff.operate               <= `ODAC_CTRL_RST;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign hrdata    = r_ff.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Master clear only; holding slave clear keeps the sequencer still
  assign accumulator_clear_pulse = r_ff.clr_pulse;
  assign accumulator_clear_slave = 1'b0;
  assign roundoff_gate           = r_ff.rnd_gate;

  // Step requests are held off while roundoff is pending
  assign step_one_req  = (r_ff.st == ODAC_STEP) & ~r_ff.step_seen &
                         r_ff.ord.shift_direction_flag &
                         ~r_ff.ord.roundoff_flag;
  assign step_zero_req = (r_ff.st == ODAC_STEP) & ~r_ff.step_seen &
                         ~r_ff.ord.shift_direction_flag &
                         ~r_ff.ord.roundoff_flag;
  assign shift_right   = r_ff.ord.shift_direction_flag;
  assign shift_left    = ~r_ff.ord.shift_direction_flag;

  assign complement_subtract = r_ff.comp_sub;
  assign adder_carry_in      = r_ff.comp_sub;
  assign op_go               = r_ff.go;
  assign op_done             = r_ff.fin;
  assign reg2_frac1_load     = r_ff.r2_load;
  assign reg2_frac1_data     = r_ff.r2_data;

  // Order decode
  assign mem_action    = odac_mem_type'({r_ff.ord.memory_use_flag,
                         r_ff.ord.read_write_target_flag});
  assign add_class     = r_ff.ord.add_vs_multiply_flag;
  assign mul_div_class = ~r_ff.ord.add_vs_multiply_flag;
  assign reg2_select   = r_ff.ord.second_reg_select_flag &
                         r_ff.ord.add_vs_multiply_flag;
  assign multiply_pos  = ~r_ff.ord.add_vs_multiply_flag &
                         ~r_ff.ord.number_absval_flag;
  assign extract_pos   = ~r_ff.ord.add_vs_multiply_flag &
                         r_ff.ord.number_absval_flag;
  assign matrix_code   = {r_ff.ord.add_sub_flag,
                          r_ff.ord.number_absval_flag};

endmodule : odac_top

// ---- include/odac_defines.svh ----
`ifndef ODAC_DEFINES_SVH
`define ODAC_DEFINES_SVH

// Register byte offsets
`define ODAC_ORDER_OFS      8'h00
`define ODAC_CTRL_OFS       8'h04
`define ODAC_STATUS_OFS     8'h08
`define ODAC_PINS_OFS       8'h0c

// Order field positions
`define ODAC_ROUNDOFF_BIT   0
`define ODAC_ADD_SUB_BIT    1
`define ODAC_ABSVAL_BIT     2
`define ODAC_CLEAR_BIT      3
`define ODAC_REG2_BIT       4
`define ODAC_MEM_USE_BIT    5
`define ODAC_RW_TGT_BIT     6
`define ODAC_ADD_MUL_BIT    7
`define ODAC_DIR_BIT        8
`define ODAC_ORDER_W        9

// Control register fields
`define ODAC_CTL_OPERATE    0

// Reset values
`define ODAC_ORDER_RST      9'h000
`define ODAC_CTRL_RST       1'b0

// Timing counts
`define ODAC_ADD_STEPS      4'h8
`define ODAC_RIGHT_STEPS    4'h4

`endif

// ---- include/odac_pkg.sv ----
package odac_pkg;

  typedef enum logic [2:0] {
    ODAC_IDLE    = 3'b000,
    ODAC_CLEAR   = 3'b001,
    ODAC_CLRWAIT = 3'b010,
    ODAC_ROUND   = 3'b011,
    ODAC_COMP    = 3'b100,
    ODAC_STEP    = 3'b101,
    ODAC_DONE    = 3'b110,
    ODAC_STALL   = 3'b111
  } odac_state_type;

  typedef enum logic [1:0] {
    ODAC_MEM_SHIFT_CNT = 2'b00,
    ODAC_MEM_ORDER_CNT = 2'b01,
    ODAC_MEM_WRITE     = 2'b10,
    ODAC_MEM_READ      = 2'b11
  } odac_mem_type;

  typedef struct packed {
    logic shift_direction_flag;
    logic add_vs_multiply_flag;
    logic read_write_target_flag;
    logic memory_use_flag;
    logic second_reg_select_flag;
    logic clear_hold_flag;
    logic number_absval_flag;
    logic add_sub_flag;
    logic roundoff_flag;
  } odac_order_type;

  // Two-stage synchronisers for the five pins
  typedef struct packed {
    logic [4:0] s1;
    logic [4:0] s2;
  } odac_sync_type;

  typedef struct packed {
    odac_state_type st;
    odac_order_type ord;
    logic           operate;
    logic           pending;
    logic           comp_sub;
    logic           complement_check_flag;
    logic [3:0]     step_cnt;
    logic           step_seen;
    logic           clr_pulse;
    logic           rnd_gate;
    logic           go;
    logic           fin;
    logic           r2_load;
    logic           r2_data;
    odac_sync_type  sy;
    logic           ap_wr;
    logic           ap_sel;
    logic [7:0]     ap_addr;
    logic [31:0]    rdata;
  } odac_regs_type;

endpackage : odac_pkg
